// ### verilog/cmf_pkg.sv
/*
  Shared constants and types for the cell monitor command frame decoder:
  frame initialization byte layout, request types, register addresses and
  frame sizes. Assumes a byte-wide link already deframed from the UART.
*/
package cmf_pkg;
  // frame initialization byte layout
  typedef struct packed {
    logic frame_kind_bit;
    logic [2:0] req_type;
    logic addr_size;
    logic [2:0] data_size;
  } cmf_init_s;

  localparam logic [2:0] REQ_SINGLE_RESP = 3'h0;
  localparam logic [2:0] REQ_SINGLE_NORESP = 3'h1;
  localparam logic ADDR_SIZE_8 = 1'h0;
  localparam logic FRAME_CMD = 1'h1;
  localparam logic FRAME_RESP = 1'h0;
  // a data size field of 7 stands for eight bytes
  localparam logic [2:0] DSZ_MAX_CODE = 3'h7;
  localparam logic [3:0] DSZ_MAX_BYTES = 4'h8;
  localparam logic [2:0] DSZ_CHAN = 3'h5;
  localparam logic [2:0] DSZ_CHAN_AVG = 3'h6;
  localparam int BUF_DEPTH = 8;

  // register addresses
  localparam logic [7:0] ADDR_COMMAND = 8'h02;
  localparam logic [7:0] ADDR_CHAN_B3 = 8'h03;
  localparam logic [7:0] ADDR_CHAN_B2 = 8'h04;
  localparam logic [7:0] ADDR_CHAN_B1 = 8'h05;
  localparam logic [7:0] ADDR_CHAN_B0 = 8'h06;
  localparam logic [7:0] ADDR_AVERAGING = 8'h07;
  localparam logic [7:0] ADDR_NODE = 8'h0A;

  // data byte positions inside a sampling command
  localparam int POS_CMD = 0;
  localparam int POS_CHAN = 1;
  localparam int POS_AVG = 5;

  localparam logic [31:0] CHAN_RESET = 32'h0000_0000;
  localparam logic [7:0] AVG_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // crc defaults: register preset and generator
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
endpackage : cmf_pkg

// ### verilog/cmf_crc.sv
/*
  Byte-serial CRC-16, most significant bit first.
  Assumes the caller clears it at frame start and feeds one byte per strobe.
*/
`timescale 1ns/1ns
module cmf_crc #(
  parameter logic [15:0] POLY = cmf_pkg::CRC_POLY,
  parameter logic [15:0] INIT = cmf_pkg::CRC_INIT
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc_r
);
  import cmf_pkg::*;
  logic [15:0] crc_nxt;

  always_comb begin
    logic [15:0] c;
    c = crc_r;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
    end
    if (clear) begin
      crc_nxt = INIT;
    end else if (en) begin
      crc_nxt = c;
    end else begin
      crc_nxt = crc_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      crc_r <= INIT;
    end else if (ce) begin
      crc_r <= crc_nxt;
    end
  end
endmodule : cmf_crc

// ### verilog/cmf_decoder.sv
/*
  Command frame decoder and response builder for one monitor on the
  daisy-chained link. Takes command bytes one at a time, checks the frame,
  updates the sampling registers and sends the response frame.
  Assumes bytes arrive already deframed and synchronous to clk_sys, and an
  outside converter returns one 16-bit result per selected channel.
*/
`timescale 1ns/1ns
module cmf_decoder #(
  parameter logic [7:0] NODE_RESET = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_ready_r,
  output logic [7:0] tx_byte_r,
  output logic tx_valid_r,
  input wire logic tx_ready,
  output logic sample_start_r,
  input wire logic [15:0] res_word,
  input wire logic res_valid,
  output logic res_ready_r,
  output logic [7:0] command_r,
  output logic [31:0] channel_select_r,
  output logic [7:0] averaging_config_r,
  output logic [7:0] node_address_r,
  output logic crc_error_r
);
  import cmf_pkg::*;

  typedef enum logic [3:0] {
    ST_INIT, ST_DEV, ST_ADDR_HI, ST_ADDR, ST_DATA, ST_CRC_H, ST_CRC_L, ST_EXEC,
    ST_TX_INIT, ST_TX_DATA, ST_TX_CRC_H, ST_TX_CRC_L
  } cmf_state_e;

  cmf_state_e state_r, state_nxt;
  cmf_init_s init_r, init_nxt;
  logic [7:0] dev_r, dev_nxt, addr_r, addr_nxt;
  logic [7:0] buf_r [BUF_DEPTH];
  logic [7:0] buf_nxt [BUF_DEPTH];
  logic [3:0] cnt_r, cnt_nxt, need_r, need_nxt;
  logic [8:0] left_r, left_nxt;
  logic sample_mode_r, sample_mode_nxt, lo_half_r, lo_half_nxt;
  logic [15:0] res_r, res_nxt;
  logic rx_ready_nxt, tx_valid_nxt, sample_start_nxt, res_ready_nxt, crc_error_nxt;
  logic [7:0] tx_byte_nxt, command_nxt, averaging_nxt, node_nxt;
  logic [31:0] channel_nxt;
  logic [15:0] rx_crc, tx_crc;
  logic rx_take, tx_take, rx_crc_clr, tx_crc_clr, tx_crc_en;

  assign rx_take = rx_valid && rx_ready_r;
  assign tx_take = tx_valid_r && tx_ready;

  // every received byte, including the CRC pair, runs through the checker
  cmf_crc u_rx_crc (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .clear(rx_crc_clr),
    .en(rx_take), .data(rx_byte), .crc_r(rx_crc)
  );
  cmf_crc u_tx_crc (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .clear(tx_crc_clr),
    .en(tx_crc_en), .data(tx_byte_r), .crc_r(tx_crc)
  );

  function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] cmd,
      input logic [31:0] ch, input logic [7:0] av, input logic [7:0] nd);
    unique case (a)
      ADDR_COMMAND: read_byte = cmd;
      ADDR_CHAN_B3: read_byte = ch[31:24];
      ADDR_CHAN_B2: read_byte = ch[23:16];
      ADDR_CHAN_B1: read_byte = ch[15:8];
      ADDR_CHAN_B0: read_byte = ch[7:0];
      ADDR_AVERAGING: read_byte = av;
      ADDR_NODE: read_byte = nd;
      default: read_byte = 8'h00;
    endcase
  endfunction

  always_comb begin
    logic [7:0] wa;
    logic [6:0] nsel;
    state_nxt = state_r;
    init_nxt = init_r;
    dev_nxt = dev_r;
    addr_nxt = addr_r;
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    need_nxt = need_r;
    left_nxt = left_r;
    sample_mode_nxt = sample_mode_r;
    lo_half_nxt = lo_half_r;
    res_nxt = res_r;
    rx_ready_nxt = rx_ready_r;
    tx_valid_nxt = tx_valid_r;
    tx_byte_nxt = tx_byte_r;
    sample_start_nxt = 1'b0;
    res_ready_nxt = res_ready_r;
    crc_error_nxt = 1'b0;
    command_nxt = command_r;
    channel_nxt = channel_select_r;
    averaging_nxt = averaging_config_r;
    node_nxt = node_address_r;
    rx_crc_clr = 1'b0;
    tx_crc_clr = 1'b0;
    tx_crc_en = 1'b0;
    wa = 8'h00;
    nsel = 7'h00;
    for (int i = 0; i < 32; i++) begin
      nsel = nsel + 7'(channel_select_r[i]);
    end
    unique case (state_r)
      ST_INIT: begin
        rx_ready_nxt = 1'b1;
        if (rx_take) begin
          init_nxt = cmf_init_s'(rx_byte);
          need_nxt = (rx_byte[2:0] == DSZ_MAX_CODE) ? DSZ_MAX_BYTES : {1'b0, rx_byte[2:0]};
          cnt_nxt = 4'h0;
          state_nxt = ST_DEV;
        end
      end
      ST_DEV: if (rx_take) begin
        dev_nxt = rx_byte;
        state_nxt = (init_r.addr_size == ADDR_SIZE_8) ? ST_ADDR : ST_ADDR_HI;
      end
      // wide addresses keep only the low byte; no register sits above 0xFF
      ST_ADDR_HI: if (rx_take) state_nxt = ST_ADDR;
      ST_ADDR: if (rx_take) begin
        addr_nxt = rx_byte;
        state_nxt = (need_r == 4'h0) ? ST_CRC_H : ST_DATA;
      end
      ST_DATA: if (rx_take) begin
        buf_nxt[cnt_r[2:0]] = rx_byte;
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r + 4'h1 == need_r) state_nxt = ST_CRC_H;
      end
      ST_CRC_H: if (rx_take) state_nxt = ST_CRC_L;
      ST_CRC_L: if (rx_take) begin
        rx_ready_nxt = 1'b0;
        state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        state_nxt = ST_INIT;
        rx_crc_clr = 1'b1;
        if (rx_crc != CRC_GOOD) begin
          crc_error_nxt = 1'b1;
        end else if (init_r.frame_kind_bit == FRAME_CMD && dev_r == node_address_r) begin
          if (init_r.req_type == REQ_SINGLE_NORESP) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
              wa = addr_r + 8'(i);
              if (4'(i) < need_r) begin
                unique case (wa)
                  ADDR_COMMAND: command_nxt = buf_r[i];
                  ADDR_CHAN_B3: channel_nxt[31:24] = buf_r[i];
                  ADDR_CHAN_B2: channel_nxt[23:16] = buf_r[i];
                  ADDR_CHAN_B1: channel_nxt[15:8] = buf_r[i];
                  ADDR_CHAN_B0: channel_nxt[7:0] = buf_r[i];
                  ADDR_AVERAGING: averaging_nxt = buf_r[i];
                  ADDR_NODE: node_nxt = buf_r[i];
                  default: ;
                endcase
              end
            end
          end else if (init_r.req_type == REQ_SINGLE_RESP) begin
            tx_crc_clr = 1'b1;
            state_nxt = ST_TX_INIT;
            if (addr_r == ADDR_COMMAND) begin
              sample_mode_nxt = 1'b1;
              if (need_r != 4'h0) command_nxt = buf_r[POS_CMD];
              // shorter frames keep the stored selection and averaging
              if (need_r >= {1'b0, DSZ_CHAN}) begin
                channel_nxt = {buf_r[POS_CHAN], buf_r[POS_CHAN + 1],
                               buf_r[POS_CHAN + 2], buf_r[POS_CHAN + 3]};
              end
              if (need_r >= {1'b0, DSZ_CHAN_AVG}) averaging_nxt = buf_r[POS_AVG];
              sample_start_nxt = 1'b1;
            end else begin
              sample_mode_nxt = 1'b0;
              left_nxt = {1'b0, buf_r[0]} + 9'h001;
            end
          end
        end
      end
      ST_TX_INIT: begin
        // selection is final here, so the sample count is taken now
        if (!tx_valid_r) begin
          if (sample_mode_r) left_nxt = {1'b0, nsel, 1'b0};
          tx_byte_nxt = {FRAME_RESP, 7'(left_nxt - 9'h001)};
          tx_valid_nxt = 1'b1;
          lo_half_nxt = 1'b0;
        end else if (tx_take) begin
          tx_valid_nxt = 1'b0;
          tx_crc_en = 1'b1;
          state_nxt = (left_r == 9'h000) ? ST_TX_CRC_H : ST_TX_DATA;
        end
      end
      ST_TX_DATA: begin
        if (!tx_valid_r) begin
          if (!sample_mode_r) begin
            tx_byte_nxt = read_byte(addr_r, command_r, channel_select_r,
                                    averaging_config_r, node_address_r);
            tx_valid_nxt = 1'b1;
          end else if (lo_half_r) begin
            tx_byte_nxt = res_r[7:0];
            tx_valid_nxt = 1'b1;
          end else begin
            // result handshake stalls the reply until the converter delivers
            res_ready_nxt = !(res_valid && res_ready_r);
            if (res_valid && res_ready_r) begin
              res_nxt = res_word;
              tx_byte_nxt = res_word[15:8];
              tx_valid_nxt = 1'b1;
            end
          end
        end else if (tx_take) begin
          tx_valid_nxt = 1'b0;
          tx_crc_en = 1'b1;
          addr_nxt = addr_r + 8'h01;
          lo_half_nxt = !lo_half_r;
          left_nxt = left_r - 9'h001;
          if (left_r == 9'h001) state_nxt = ST_TX_CRC_H;
        end
      end
      ST_TX_CRC_H: begin
        if (!tx_valid_r) begin
          tx_byte_nxt = tx_crc[15:8];
          tx_valid_nxt = 1'b1;
        end else if (tx_take) begin
          tx_valid_nxt = 1'b0;
          state_nxt = ST_TX_CRC_L;
        end
      end
      ST_TX_CRC_L: begin
        if (!tx_valid_r) begin
          tx_byte_nxt = tx_crc[7:0];
          tx_valid_nxt = 1'b1;
        end else if (tx_take) begin
          tx_valid_nxt = 1'b0;
          rx_ready_nxt = 1'b1;
          state_nxt = ST_INIT;
        end
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_INIT;
      init_r <= '0;
      dev_r <= 8'h00;
      addr_r <= 8'h00;
      for (int i = 0; i < BUF_DEPTH; i++) buf_r[i] <= 8'h00;
      cnt_r <= 4'h0;
      need_r <= 4'h0;
      left_r <= 9'h000;
      sample_mode_r <= 1'b0;
      lo_half_r <= 1'b0;
      res_r <= 16'h0000;
      rx_ready_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
      sample_start_r <= 1'b0;
      res_ready_r <= 1'b0;
      crc_error_r <= 1'b0;
      command_r <= CMD_RESET;
      channel_select_r <= CHAN_RESET;
      averaging_config_r <= AVG_RESET;
      node_address_r <= NODE_RESET;
    end else if (ce) begin
      state_r <= state_nxt;
      init_r <= init_nxt;
      dev_r <= dev_nxt;
      addr_r <= addr_nxt;
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
      need_r <= need_nxt;
      left_r <= left_nxt;
      sample_mode_r <= sample_mode_nxt;
      lo_half_r <= lo_half_nxt;
      res_r <= res_nxt;
      rx_ready_r <= rx_ready_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_byte_r <= tx_byte_nxt;
      sample_start_r <= sample_start_nxt;
      res_ready_r <= res_ready_nxt;
      crc_error_r <= crc_error_nxt;
      command_r <= command_nxt;
      channel_select_r <= channel_nxt;
      averaging_config_r <= averaging_nxt;
      node_address_r <= node_nxt;
    end
  end
endmodule : cmf_decoder

// ### dv/cmf_monitor.sv
/*
  Port-level checker for cmf_decoder.
  Assumes one clock domain and a bind onto every decoder instance.
*/
`timescale 1ns/1ns
module cmf_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic rx_ready_r,
  input wire logic [7:0] tx_byte_r,
  input wire logic tx_valid_r,
  input wire logic tx_ready,
  input wire logic sample_start_r,
  input wire logic [15:0] res_word,
  input wire logic res_valid,
  input wire logic res_ready_r,
  input wire logic [31:0] channel_select_r,
  input wire logic [7:0] averaging_config_r,
  input wire logic crc_error_r
);
  logic first_r, first_nxt, take, res_take;
  logic [6:0] samp_len;
  logic [7:0] res_hi;
  assign take = ce && tx_valid_r && tx_ready;
  assign res_take = ce && res_valid && res_ready_r;
  assign res_hi = res_word[15:8];
  // zero channels wraps to 7F, same as the reply header
  assign samp_len = 7'(2 * $countones(channel_select_r) - 1);
  always_comb begin
    first_nxt = first_r;
    if (take) first_nxt = 1'b0;
    else if (sample_start_r) first_nxt = 1'b1;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) first_r <= 1'b0;
    else first_r <= first_nxt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_tx_holds_byte: assert property (
    tx_valid_r && !take |=> tx_valid_r && $stable(tx_byte_r)) else $error("tx byte moved early");
  a_rx_shut_reply: assert property (
    tx_valid_r |-> !rx_ready_r) else $error("rx open during reply");
  a_crc_err_mute: assert property (
    crc_error_r |=> (!tx_valid_r) [*8]) else $error("reply after bad crc");
  a_crc_err_pulse: assert property (
    crc_error_r && ce |=> !crc_error_r) else $error("crc error not a pulse");
  a_crc_keeps_regs: assert property (
    crc_error_r |=> ($stable(channel_select_r) && $stable(averaging_config_r)) [*4])
    else $error("registers changed after bad crc");
  a_start_pulse: assert property (
    sample_start_r && ce |=> !sample_start_r) else $error("sample start not a pulse");
  a_samp_init_len: assert property (
    first_r && tx_valid_r |-> tx_byte_r == {1'b0, samp_len}) else $error("bad sample header");
  a_res_hi_first: assert property (
    res_take |=> tx_valid_r && tx_byte_r == $past(res_hi)) else $error("result high byte lost");
  a_res_one_word: assert property (
    res_take |=> !res_ready_r) else $error("result ready held after take");
  c_sample: cover property (sample_start_r);
  c_crc_err: cover property (crc_error_r);
  c_res_take: cover property (res_take);
  c_tx_stall: cover property (tx_valid_r && !tx_ready);
endmodule : cmf_monitor

bind cmf_decoder cmf_monitor mon (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
  .rx_ready_r(rx_ready_r), .tx_byte_r(tx_byte_r), .tx_valid_r(tx_valid_r),
  .tx_ready(tx_ready), .sample_start_r(sample_start_r), .res_word(res_word),
  .res_valid(res_valid), .res_ready_r(res_ready_r), .channel_select_r(channel_select_r),
  .averaging_config_r(averaging_config_r), .crc_error_r(crc_error_r));

// ### dv/cmf_host_model.sv
/*
  Far side of the decoder: host link taking reply bytes, plus the sample
  source handing one result word per channel. Assumes clk_sys only.
*/
`timescale 1ns/1ns
module cmf_host_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic res_ready,
  output logic [15:0] res_word,
  output logic res_valid
);
  logic [7:0] got_q[$];
  logic [7:0] idx;
  logic [1:0] cnt;
  logic [15:0] word;
  assign word = {8'hC5, idx};
  // no held value while idle, so a stale word can never pass
  assign res_word = res_valid ? word : (cnt[0] ? ~word : word ^ 16'h5A5A);
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_ready <= 1'b0;
      res_valid <= 1'b0;
      cnt <= 2'h0;
      idx <= 8'h00;
    end else begin
      cnt <= cnt + 2'h1;
      if (tx_valid && tx_ready) got_q.push_back(tx_byte);
      tx_ready <= !slow || cnt == 2'h3;
      if (res_valid && res_ready) begin
        res_valid <= 1'b0;
        idx <= idx + 8'h01;
      end else if (!slow || cnt[1]) res_valid <= 1'b1;
    end
  end
endmodule : cmf_host_model

// ### dv/tb_top.sv
/*
  Self-checking bench for cmf_decoder: sends command frames byte by byte
  and checks the replies gathered by the host model.
  Assumes node address resets to zero; ce is high except one short freeze.
*/
`timescale 1ns/1ns
module tb_top;
  import cmf_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic slow = 1'b0;
  logic freeze = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_ready_r, tx_valid_r, tx_ready, sample_start_r, res_valid, res_ready_r, crc_error_r;
  logic [7:0] tx_byte_r, command_r, averaging_config_r, node_address_r;
  logic [15:0] res_word;
  logic [31:0] channel_select_r;
  int fails = 0;
  int compares = 0;
  int crc_errs = 0;
  int starts = 0;
  always #5 clk_sys = ~clk_sys;
  // pulses are counted mid-cycle, clear of the edge that launches them
  always @(negedge clk_sys) if (crc_error_r === 1'b1) crc_errs++;
  always @(negedge clk_sys) if (sample_start_r === 1'b1) starts++;
  cmf_decoder #(.NODE_RESET(8'h00)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready_r(rx_ready_r), .tx_byte_r(tx_byte_r),
    .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .sample_start_r(sample_start_r),
    .res_word(res_word), .res_valid(res_valid), .res_ready_r(res_ready_r),
    .command_r(command_r), .channel_select_r(channel_select_r),
    .averaging_config_r(averaging_config_r), .node_address_r(node_address_r),
    .crc_error_r(crc_error_r));
  cmf_host_model host (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .tx_byte(tx_byte_r),
    .tx_valid(tx_valid_r), .tx_ready(tx_ready), .res_ready(res_ready_r),
    .res_word(res_word), .res_valid(res_valid));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction : crc8
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    int n;
    c = CRC_INIT;
    foreach (f[i]) c = crc8(c, f[i]);
    c[0] = c[0] ^ bad;
    f.push_back(c[15:8]);
    f.push_back(c[7:0]);
    foreach (f[i]) begin
      rx_byte = f[i];
      rx_valid = 1'b1;
      n = 0;
      // a frozen clock enable must leave the offered byte untaken
      if (freeze && i == 2) begin
        ce = 1'b0;
        repeat (4) @(negedge clk_sys);
        ce = 1'b1;
      end
      while (rx_ready_r !== 1'b1 && n < 500) begin
        @(negedge clk_sys);
        n++;
      end
      if (n == 500) begin
        fails++;
        complete_run();
      end
      @(negedge clk_sys);
    end
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask : send
  task automatic reply(input string nm, input logic [7:0] exp[$]);
    logic [15:0] c;
    int n;
    c = CRC_INIT;
    n = 0;
    while (host.got_q.size() < exp.size() + 2 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 3000) begin
      fails++;
      complete_run();
    end
    repeat (20) @(negedge clk_sys);
    chk({nm, " len"}, host.got_q.size(), exp.size() + 2);
    foreach (exp[i]) chk(nm, host.got_q[i], exp[i]);
    foreach (host.got_q[i]) c = crc8(c, host.got_q[i]);
    chk({nm, " crc"}, c, CRC_GOOD);
    host.got_q.delete();
    $display("done %s", nm);
  endtask : reply
  task automatic quiet(input string nm);
    repeat (60) @(negedge clk_sys);
    chk({nm, " silent"}, host.got_q.size(), 0);
    host.got_q.delete();
    $display("done %s", nm);
  endtask : quiet
  task automatic sample(input string nm, input logic [7:0] f[$], input int nch);
    logic [7:0] exp[$];
    logic [7:0] base;
    base = host.idx;
    send(f, 1'b0);
    exp.push_back({1'b0, 7'(2 * nch - 1)});
    for (int k = 0; k < nch; k++) begin
      exp.push_back(8'hC5);
      exp.push_back(base + 8'(k));
    end
    reply(nm, exp);
  endtask : sample
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    chk("chan reset", channel_select_r, CHAN_RESET);
    chk("node reset", node_address_r, 8'h00);
    send({8'h95, 8'h00, ADDR_CHAN_B3, 8'h0F, 8'hFF, 8'h55, 8'h00, 8'h05}, 1'b0);
    quiet("write");
    chk("chan", channel_select_r, 32'h0FFF5500);
    chk("avg", averaging_config_r, 8'h05);
    slow = 1'b1;
    send({8'h81, 8'h00, ADDR_CHAN_B3, 8'h07}, 1'b0);
    reply("read", {8'h07, 8'h0F, 8'hFF, 8'h55, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00});
    sample("samp1", {8'h81, 8'h00, ADDR_COMMAND, 8'h20}, 16);
    chk("cmd", command_r, 8'h20);
    chk("chan kept", channel_select_r, 32'h0FFF5500);
    slow = 1'b0;
    sample("samp5", {8'h85, 8'h00, ADDR_COMMAND, 8'h40, 8'hFF, 8'hFF, 8'h01,
      8'h00}, 17);
    chk("chan5", channel_select_r, 32'hFFFF0100);
    chk("avg kept", averaging_config_r, 8'h05);
    sample("samp6", {8'h86, 8'h00, ADDR_COMMAND, 8'h60, 8'hFF, 8'hFF, 8'h0F, 8'h00,
      8'h7B}, 20);
    chk("avg6", averaging_config_r, 8'h7B);
    send({8'h91, 8'h00, ADDR_AVERAGING, 8'h11}, 1'b1);
    quiet("bad crc");
    chk("crc errs", crc_errs, 1);
    chk("avg held", averaging_config_r, 8'h7B);
    send({8'h89, 8'h00, 8'h00, ADDR_AVERAGING, 8'h00}, 1'b0);
    reply("wide addr", {8'h00, 8'h7B});
    send({8'h81, 8'h05, ADDR_NODE, 8'h00}, 1'b0);
    quiet("other node");
    send({8'h91, 8'h00, ADDR_NODE, 8'h05}, 1'b0);
    quiet("set node");
    freeze = 1'b1;
    send({8'h81, 8'h05, ADDR_NODE, 8'h00}, 1'b0);
    freeze = 1'b0;
    reply("new node", {8'h00, 8'h05});
    chk("starts", starts, 3);
    complete_run();
  end
endmodule : tb_top
